// file: dv/adc_seq_monitor.sv
// checker on the sequencing block's ports
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module adc_seq_monitor
	import adc_seq_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic              sys_clk,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic              timer_timeout,
	input wire logic              ext_trigger_pin,
	input wire logic [3:0]        hold_mask,
	input wire logic              conv_start,
	input wire conv_req_t         conv_req,
	input wire logic              res_valid,
	input wire logic              res_ready,
	input wire logic [RES_W-1:0]  res_value,
	input wire logic              converter_irq_flag
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// read data only in the answer cycle
	property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside answer cycle");
	property p_start_pulse; conv_start |=> !conv_start; endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("convert start longer than one cycle");
	// acquisition has ended before a conversion starts
	property p_start_hold; conv_start |-> hold_mask == 4'h0; endproperty
	a_start_hold: assert property (p_start_hold)
		else $error("convert start while acquiring");
	property p_mask_shape; $onehot0(hold_mask) || hold_mask == 4'h3 || hold_mask == 4'hf; endproperty
	a_mask_shape: assert property (p_mask_shape)
		else $error("illegal sample channel set");
	property p_req_hold; !conv_start |-> $stable(conv_req); endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("request changed without start");
	// flag is sticky until software clears it
	property p_irq_sticky;
		converter_irq_flag && !(reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_IRQ])
			|=> converter_irq_flag;
	endproperty
	a_irq_sticky: assert property (p_irq_sticky)
		else $error("interrupt flag dropped by itself");
	property p_irq_clear;
		reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_IRQ] && !res_valid && !conv_start
			&& hold_mask == 4'h0 |=> !converter_irq_flag;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("interrupt flag not cleared");
	property p_irq_quiet; $rose(converter_irq_flag) |-> hold_mask == 4'h0 && !conv_start; endproperty
	a_irq_quiet: assert property (p_irq_quiet)
		else $error("interrupt raised mid sequence");
endmodule // adc_seq_monitor

bind adc_sequence_control adc_seq_monitor #(.DEPTH(DEPTH)) u_adc_seq_monitor (
	.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.timer_timeout(timer_timeout), .ext_trigger_pin(ext_trigger_pin),
	.hold_mask(hold_mask), .conv_start(conv_start), .conv_req(conv_req),
	.res_valid(res_valid), .res_ready(res_ready), .res_value(res_value),
	.converter_irq_flag(converter_irq_flag)
);
`default_nettype wire

// file: dv/conv_core_model.sv
// converter core model: one result per convert start, random latency
// assumes the block never starts a conversion while a result is pending
`timescale 1ns/100ps
`default_nettype none
module conv_core_model
	import adc_seq_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             conv_start,
	input  wire conv_req_t        conv_req,
	input  wire logic             res_ready,
	output logic                  res_valid,
	output logic      [RES_W-1:0] res_value
);
	logic [RES_W-1:0] v;

	// result encodes channel, mux and input so the bench can trace routing
	initial begin
		res_valid = 1'b0;
		res_value = '0;
		forever begin
			@(posedge sys_clk);
			if (conv_start && !rst) begin
				v = {conv_req.chan, conv_req.mux_b, (conv_req.chan == 2'h0) ? conv_req.ch0_input : 4'h0, 3'h5};
				repeat ($urandom_range(4, 0)) @(posedge sys_clk);
				res_valid <= 1'b1;
				res_value <= v;
				do @(posedge sys_clk); while (!res_ready);
				res_valid <= 1'b0;
				res_value <= ~v; // stale value never looks valid
			end
		end
	end
endmodule // conv_core_model
`default_nettype wire

// file: dv/tb_top.sv
// bench: register-port driver, buffer model and scenario table
// assumes the core model answers every convert start
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import adc_seq_pkg::*;
;
	logic              sys_clk, rst, reg_wr, reg_rd, timer_timeout, ext_trigger_pin;
	logic              res_valid, res_ready, conv_start, converter_irq_flag;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_v, c1, scan_m;
	logic [3:0]        hold_mask, in_a, in_b;
	logic [RES_W-1:0]  res_value;
	logic [RES_W-1:0]  buf_m [BUF_WORDS];
	logic [15:0]       known;
	conv_req_t         conv_req;
	int                miscompares, comparisons, cycles, half;
	logic [15:0]       c2_t [6] = '{16'h0000, 16'h0105, 16'h0208, 16'h020c, 16'h0414, 16'h041e};
	int                src_t [6] = '{0, 1, 2, 0, 1, 2};
	bit                sim_t [6] = '{0, 0, 1, 0, 0, 1};

	adc_sequence_control #(.DEPTH(FIFO_DEPTH)) u_adc_sequence_control (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.timer_timeout(timer_timeout), .ext_trigger_pin(ext_trigger_pin),
		.hold_mask(hold_mask), .conv_start(conv_start), .conv_req(conv_req),
		.res_valid(res_valid), .res_ready(res_ready), .res_value(res_value),
		.converter_irq_flag(converter_irq_flag));
	conv_core_model u_conv_core_model (.sys_clk(sys_clk), .rst(rst), .conv_start(conv_start),
		.conv_req(conv_req), .res_ready(res_ready), .res_valid(res_valid),
		.res_value(res_value));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// hang guard, far above the scenario length
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			results();
		end
	end

	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		// taken mid-cycle, clear of the edge that drops the data again
		@(negedge sys_clk);
		rd_v = reg_rdata;
	endtask

	function automatic logic [15:0] fmt(input logic [9:0] v, input int f);
		case (f)
			0: return {6'h00, v};
			1: return {{6{~v[9]}}, v ^ 10'h200};
			2: return {v, 6'h00};
			default: return {v ^ 10'h200, 6'h00};
		endcase
	endfunction

	// ext trigger held until acquisition ends, so the synchroniser sees it
	task automatic fire(input int src);
		@(posedge sys_clk);
		case (src)
			0: reg_wr <= 1'b1;
			1: timer_timeout <= 1'b1;
			default: ext_trigger_pin <= 1'b1;
		endcase
		reg_addr <= REG_CTRL_ONE;
		reg_wdata <= c1 | 16'h0004;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		timer_timeout <= 1'b0;
		while (|hold_mask) @(posedge sys_clk);
		ext_trigger_pin <= 1'b0;
	endtask

	task automatic run(input logic [15:0] c2v, input int src, input bit sim);
		int nch, nseq, fires, idx;
		logic [3:0] ci;
		logic mb;
		logic [3:0] list [$];
		nch = (c2v[9:8] == 2'h0) ? 1 : (c2v[9:8] == 2'h1) ? 2 : 4;
		nseq = c2v[5:2] + 1;
		for (int i = 0; i < INPUTS; i++)
			if (scan_m[i]) list.push_back(i[3:0]);
		// model: scan ascends from lowest each interrupt, alt swaps mux per sequence
		for (int s = 0; s < nseq; s++) begin
			mb = c2v[C2_ALT] & s[0];
			for (int c = 0; c < nch; c++) begin
				ci = c2v[C2_SCAN] ? list[s % list.size()] : mb ? in_b : in_a;
				idx = c2v[C2_SPLIT] ? half * 8 + (s * nch + c) % 8 : s * nch + c;
				buf_m[idx] = {c[1:0], mb, (c == 0) ? ci : 4'h0, 3'h5};
				known[idx] = 1'b1;
			end
		end
		if (c2v[C2_SPLIT])
			half = 1 - half;
		// single-sequence runs leave auto restart off, so the sample bit must drop
		c1 = ((nseq > 1) ? 16'h0043 : 16'h0003) | (16'(sim) << C1_SIMUL) | (16'(src) << C1_TRIG_LO);
		wr(REG_CTRL_TWO, c2v);
		wr(REG_CTRL_ONE, c1);
		fires = 0;
		while (converter_irq_flag !== 1'b1) begin
			@(posedge sys_clk);
			if (|hold_mask) begin
				check("hold mask", {12'h000, hold_mask}, 16'(sim ? (1 << nch) - 1 : 1 << (fires % nch)));
				fire(src);
				fires++;
			end
		end
		rd(REG_CTRL_ONE);
		check("control one", rd_v, (nseq > 1) ? c1 : (c1 & 16'hfffd));
		wr(REG_CTRL_ONE, 16'h0000);
		rd(REG_STATUS);
		check("status", rd_v, 16'h0003 | 16'(half << ST_HALF));
		for (int i = 0; i < BUF_WORDS; i++)
			if (known[i]) begin
				rd(i[4:0]);
				check("result word", rd_v, {6'h00, buf_m[i]});
			end
		wr(REG_STATUS, 16'h0003);
		@(posedge sys_clk);
		check("irq flag", {15'h0000, converter_irq_flag}, 16'h0000);
	endtask

	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		timer_timeout = 1'b0;
		ext_trigger_pin = 1'b0;
		{miscompares, comparisons, cycles, half} = '0;
		known = '0;
		scan_m = 16'h0a12;
		void'($urandom(32'hb15d));
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		wr(5'h1f, 16'hffff);
		for (int a = 16; a < 21; a++) begin
			rd(a[4:0]);
			check("reset value", rd_v, 16'h0000);
		end
		rd(5'h1f);
		check("unmapped", rd_v, 16'h0000);
		wr(REG_SCAN_SEL, scan_m);
		for (int i = 0; i < 6; i++) begin
			in_a = 4'($urandom);
			in_b = 4'($urandom);
			wr(REG_IN_SEL, {4'h0, in_b, 4'h0, in_a});
			for (int r = 0; r < ((i > 3) ? 2 : 1); r++)
				run(c2_t[i], src_t[i], sim_t[i]);
			if (i == 0) begin
				wr(5'h00, 16'hffff);
				for (int f = 0; f < 4; f++) begin
					wr(REG_CTRL_ONE, 16'(f << C1_FORM_LO));
					rd(5'h00);
					check("formatted word", rd_v, fmt(buf_m[0], f));
				end
			end
		end
		results();
	end
endmodule // tb_top
`default_nettype wire

// file: include/adc_seq_pkg.sv
// package for the converter sequencing block: register indices, field
// positions, reset values, sizes and shared types.
// assumes a single 25 MHz clock domain and a plain strobe-type register port.
`default_nettype none
package adc_seq_pkg;

	// register port sizes
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;

	// register indices; result words occupy indices 0 to 15
	localparam logic [ADDR_W-1:0] REG_CTRL_ONE = 5'h10;
	localparam logic [ADDR_W-1:0] REG_CTRL_TWO = 5'h11; // converter_ctrl_two
	localparam logic [ADDR_W-1:0] REG_STATUS   = 5'h12;
	localparam logic [ADDR_W-1:0] REG_SCAN_SEL = 5'h13; // scan_select_reg
	localparam logic [ADDR_W-1:0] REG_IN_SEL   = 5'h14;
	localparam logic [ADDR_W-1:0] REG_RES_LAST = 5'h0f; // result_word_last

	// first control register fields
	localparam int C1_ON      = 0;
	localparam int C1_SAMPLE  = 1;  // sample_start_bit
	localparam int C1_CONVERT = 2;  // manual trigger, write-only pulse
	localparam int C1_TRIG_LO = 3;  // 2-bit trigger source
	localparam int C1_SIMUL   = 5;  // simultaneous_sample_sel
	localparam int C1_AUTO    = 6;  // restart acquisition after a sequence
	localparam int C1_FORM_LO = 8;  // 2-bit output format

	// second control register fields
	localparam int C2_ALT     = 0;  // alternate_input_sel
	localparam int C2_SPLIT   = 1;  // split_buffer_sel
	localparam int C2_SPI_LO  = 2;  // sequences_per_irq, bits 5:2
	localparam int C2_CHAN_LO = 8;  // channel_count_sel, bits 9:8
	localparam int C2_SCAN    = 10; // scan_enable_bit

	// status register fields
	localparam int ST_DONE = 0;
	localparam int ST_IRQ  = 1;  // converter_irq_flag
	localparam int ST_HALF = 2;

	// input select register fields: mux A and mux B inputs for channel zero
	localparam int IN_A_LO = 0;
	localparam int IN_B_LO = 8;

	// reset values
	localparam logic [DATA_W-1:0] CTRL_ONE_RST = 16'h0000;
	localparam logic [DATA_W-1:0] CTRL_TWO_RST = 16'h0000;
	localparam logic [DATA_W-1:0] SCAN_SEL_RST = 16'h0000;
	localparam logic [DATA_W-1:0] IN_SEL_RST   = 16'h0000;

	// sizes
	localparam int RES_W      = 10;
	localparam int BUF_WORDS  = 16;
	localparam int HALF_WORDS = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int INPUTS     = 16;

	typedef enum logic [1:0] {
		TRIG_MANUAL = 2'h0,
		TRIG_TIMER  = 2'h1,
		TRIG_EXT    = 2'h2,
		TRIG_NONE   = 2'h3
	} trig_src_t;

	typedef enum logic [1:0] {
		FORM_UINT  = 2'h0,
		FORM_SINT  = 2'h1,
		FORM_UFRAC = 2'h2,
		FORM_SFRAC = 2'h3
	} out_form_t;

	typedef enum {S_IDLE, S_ACQ, S_ISSUE, S_WAIT} seq_state_t;

	// conversion request toward the converter core
	typedef struct packed {
		logic [1:0] chan;      // sample/hold channel to convert
		logic       mux_b;     // mux B inputs in use
		logic [3:0] ch0_input; // analog input on sample_chan_zero
	} conv_req_t;

endpackage
`default_nettype wire

// file: logic/adc_sequence_control.sv
// converter sequencing: acquisition/conversion control, result fifo and
// the 16-word result buffer behind a strobe-type register port.
// assumes the converter core runs on sys_clk; the external trigger is a pin.
`timescale 1ns/100ps
`default_nettype none

// result fifo between converter core and buffer writer
module result_fifo
	import adc_seq_pkg::*;
#(
	parameter int WIDTH = RES_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// pointer wrap relies on a power-of-two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("result_fifo depth must be a power of two, at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wp;
		logic [AW:0]                 rp;
	} fifo_state_t;

	fifo_state_t s_q, s_d;
	logic        full;
	logic        empty;

	assign full      = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
	assign empty     = (s_q.wp == s_q.rp);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = s_q.mem[s_q.rp[AW-1:0]];

	// push and pop may share a cycle
	always_comb begin
		s_d = s_q;
		if (in_valid && !full) begin
			s_d.mem[s_q.wp[AW-1:0]] = in_data;
			s_d.wp = s_q.wp + 1'b1;
		end
		if (out_ready && !empty) begin
			s_d.rp = s_q.rp + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule // result_fifo

module adc_sequence_control
	import adc_seq_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// trigger sources
	input  wire logic              timer_timeout,
	input  wire logic              ext_trigger_pin,
	// converter core
	output logic      [3:0]        hold_mask,
	output logic                   conv_start,
	output var conv_req_t          conv_req,
	input  wire logic              res_valid,
	output logic                   res_ready,
	input  wire logic [RES_W-1:0]  res_value,
	// interrupt flag as a level
	output logic                   converter_irq_flag
);

	typedef struct packed {
		seq_state_t                         st;
		logic [DATA_W-1:0]                  ctrl_one;
		logic [DATA_W-1:0]                  ctrl_two;
		logic [DATA_W-1:0]                  scan_sel;
		logic [DATA_W-1:0]                  in_sel;
		logic                               done;
		logic                               irq;
		logic                               half;
		logic [3:0]                         wr_idx;
		logic [3:0]                         seq_cnt;
		logic [1:0]                         ch;
		logic                               alt;
		logic [3:0]                         scan_pos;
		logic [2:0]                         ext_sync;
		logic [DATA_W-1:0]                  rdata;
		logic [3:0]                         hold;
		logic                               start;
		conv_req_t                          req;
		logic [BUF_WORDS-1:0][RES_W-1:0]    res_mem;
	} seq_regs_t;

	seq_regs_t  s_q, s_d;
	logic       drain_valid;
	logic       drain_ready;
	logic [RES_W-1:0] drain_data;

	// last channel index for a channel-count code
	function automatic logic [1:0] last_chan(input logic [1:0] code);
		unique case (code)
			2'h0:    last_chan = 2'h0;
			2'h1:    last_chan = 2'h1;
			default: last_chan = 2'h3;
		endcase
	endfunction

	// lowest selected input at or above start, wrapping to the lowest
	function automatic logic [3:0] next_scan(input logic [15:0] mask,
		input logic [4:0] start);
		logic       hit;
		logic [3:0] low;
		hit       = 1'b0;
		low       = 4'h0;
		next_scan = 4'h0;
		for (int i = INPUTS - 1; i >= 0; i--) begin
			if (mask[i]) begin
				low = 4'(i);
				if (5'(i) >= start) begin
					next_scan = 4'(i);
					hit       = 1'b1;
				end
			end
		end
		if (!hit) begin
			next_scan = low;
		end
	endfunction

	// 10-bit result presented as a 16-bit word
	function automatic logic [DATA_W-1:0] fmt(input logic [RES_W-1:0] v,
		input logic [1:0] form);
		logic [RES_W-1:0] sv;
		sv = {~v[RES_W-1], v[RES_W-2:0]};
		unique case (out_form_t'(form))
			FORM_UINT:  fmt = {6'h00, v};
			FORM_SINT:  fmt = {{6{sv[RES_W-1]}}, sv};
			FORM_UFRAC: fmt = {v, 6'h00};
			FORM_SFRAC: fmt = {sv, 6'h00};
		endcase
	endfunction

	// results wait in the fifo while the module is off
	result_fifo #(
		.WIDTH (RES_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_valid  (res_valid),
		.in_ready  (res_ready),
		.in_data   (res_value),
		.out_valid (drain_valid),
		.out_ready (drain_ready),
		.out_data  (drain_data)
	);

	assign drain_ready = s_q.ctrl_one[C1_ON];

	// outputs straight from state
	assign reg_rdata          = s_q.rdata;
	assign hold_mask          = s_q.hold;
	assign conv_start         = s_q.start;
	assign conv_req           = s_q.req;
	assign converter_irq_flag = s_q.irq;

	// next-state logic
	always_comb begin
		logic       trig;
		logic       wr_evt;
		logic       simul;
		logic       split;
		logic       seq_end;
		logic       irq_evt;
		logic [1:0] lastc;
		logic [3:0] spi;
		logic [3:0] waddr;
		logic [1:0] tsrc;
		trig    = 1'b0;
		seq_end = 1'b0;
		irq_evt = 1'b0;
		waddr   = 4'h0;
		s_d     = s_q;
		lastc   = last_chan(s_q.ctrl_two[C2_CHAN_LO +: 2]);
		spi     = s_q.ctrl_two[C2_SPI_LO +: 4];
		split   = s_q.ctrl_two[C2_SPLIT];
		simul   = s_q.ctrl_one[C1_SIMUL] && (lastc != 2'h0);
		tsrc    = s_q.ctrl_one[C1_TRIG_LO +: 2];
		wr_evt  = drain_valid && drain_ready;
		s_d.start = 1'b0;
		s_d.rdata = '0;

		// external trigger pin: two flops, then an edge detector
		s_d.ext_sync = {s_q.ext_sync[1:0], ext_trigger_pin};

		// conversion trigger source
		unique case (trig_src_t'(tsrc))
			TRIG_MANUAL: trig = reg_wr && reg_addr == REG_CTRL_ONE && reg_wdata[C1_CONVERT];
			TRIG_TIMER:  trig = timer_timeout;
			TRIG_EXT:    trig = s_q.ext_sync[1] && !s_q.ext_sync[2];
			TRIG_NONE:   trig = 1'b0;
		endcase

		// buffer writer; result words are never written by software
		if (wr_evt) begin
			waddr = split ? {s_q.half, s_q.wr_idx[2:0]} : s_q.wr_idx;
			s_d.res_mem[waddr] = drain_data;
			s_d.wr_idx = s_q.wr_idx + 4'h1;
		end

		// acquisition and conversion sequencer
		unique case (s_q.st)
			S_IDLE: begin
				s_d.hold = 4'h0;
				if (s_q.ctrl_one[C1_ON] && s_q.ctrl_one[C1_SAMPLE]) begin
					s_d.st = S_ACQ;
				end
			end
			S_ACQ: begin
				// simultaneous mode holds every channel on one sample clock
				s_d.hold = simul ? 4'((5'h2 << lastc) - 5'h1) : 4'(4'h1 << s_q.ch);
				if (trig) begin
					s_d.hold = 4'h0;
					s_d.st   = S_ISSUE;
				end
			end
			S_ISSUE: begin
				s_d.start       = 1'b1;
				s_d.req.chan    = s_q.ch;
				s_d.req.mux_b   = s_q.alt;
				s_d.req.ch0_input = s_q.ctrl_two[C2_SCAN] ? s_q.scan_pos
					: (s_q.alt ? s_q.in_sel[IN_B_LO +: 4] : s_q.in_sel[IN_A_LO +: 4]);
				s_d.st          = S_WAIT;
			end
			S_WAIT: begin
				if (wr_evt) begin
					if (s_q.ch != lastc) begin
						s_d.ch = s_q.ch + 2'h1;
						s_d.st = simul ? S_ISSUE : S_ACQ;
					end else begin
						seq_end = 1'b1;
					end
				end
			end
		endcase

		// end of one acquisition/conversion sequence
		if (seq_end) begin
			s_d.ch  = 2'h0;
			s_d.alt = s_q.ctrl_two[C2_ALT] ? ~s_q.alt : 1'b0;
			if (s_q.seq_cnt == spi) begin
				// count reached: flag, rewind the writer, swap halves
				irq_evt     = 1'b1;
				s_d.seq_cnt = 4'h0;
				s_d.wr_idx  = 4'h0;
				s_d.half    = split ? ~s_q.half : 1'b0;
				s_d.scan_pos = next_scan(s_q.scan_sel, 5'h00);
			end else begin
				s_d.seq_cnt  = s_q.seq_cnt + 4'h1;
				s_d.scan_pos = next_scan(s_q.scan_sel, 5'(s_q.scan_pos) + 5'h01);
			end
			if (s_q.ctrl_one[C1_AUTO]) begin
				s_d.st = S_ACQ;
			end else begin
				s_d.st = S_IDLE;
				s_d.ctrl_one[C1_SAMPLE] = 1'b0;
			end
		end

		// register writes; result indices ignore writes
		if (reg_wr) begin
			unique case (reg_addr)
				REG_CTRL_ONE: begin
					s_d.ctrl_one = reg_wdata;
					s_d.ctrl_one[C1_CONVERT] = 1'b0;
				end
				REG_CTRL_TWO: s_d.ctrl_two = reg_wdata;
				REG_SCAN_SEL: begin
					s_d.scan_sel = reg_wdata;
					s_d.scan_pos = next_scan(reg_wdata, 5'h00);
				end
				REG_IN_SEL: s_d.in_sel = reg_wdata;
				REG_STATUS: begin
					// write one to clear; a same-cycle event below wins
					if (reg_wdata[ST_DONE]) begin
						s_d.done = 1'b0;
					end
					if (reg_wdata[ST_IRQ]) begin
						s_d.irq = 1'b0;
					end
				end
				default: ;
			endcase
		end

		// switching the module off abandons the sequence in progress
		if (!s_d.ctrl_one[C1_ON]) begin
			s_d.st   = S_IDLE;
			s_d.ch   = 2'h0;
			s_d.hold = 4'h0;
		end

		// completion events win over software clears
		if (irq_evt) begin
			s_d.done = 1'b1;
			s_d.irq  = 1'b1;
		end

		// read data stands the cycle after the strobe only
		if (reg_rd) begin
			if (reg_addr <= REG_RES_LAST) begin
				s_d.rdata = fmt(s_q.res_mem[reg_addr[3:0]], s_q.ctrl_one[C1_FORM_LO +: 2]);
			end else begin
				unique case (reg_addr)
					REG_CTRL_ONE: s_d.rdata = s_q.ctrl_one;
					REG_CTRL_TWO: s_d.rdata = s_q.ctrl_two;
					REG_SCAN_SEL: s_d.rdata = s_q.scan_sel;
					REG_IN_SEL:   s_d.rdata = s_q.in_sel;
					REG_STATUS: begin
						s_d.rdata[ST_DONE] = s_q.done;
						s_d.rdata[ST_IRQ]  = s_q.irq;
						s_d.rdata[ST_HALF] = s_q.half;
					end
					default: s_d.rdata = '0;
				endcase
			end
		end
	end

	// single state register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_q          <= '0;
			s_q.st       <= S_IDLE;
			s_q.ctrl_one <= CTRL_ONE_RST;
			s_q.ctrl_two <= CTRL_TWO_RST;
			s_q.scan_sel <= SCAN_SEL_RST;
			s_q.in_sel   <= IN_SEL_RST;
		end else begin
			s_q <= s_d;
		end
	end
endmodule // adc_sequence_control
`default_nettype wire
